// file: design/pcie_port_width_partitioning.sv
// Functional notes
// - Ports four and five may merge to x8.
// - Ports six and seven may merge to x8.
// - Merged pair is controlled by lower port.
// - Halves train alone, merge on shared far ID.
// - Both ends step down until training succeeds.
// - Sampled width strap overrides autonomous decisions.
// - Low strap codes select four-to-seven pairing.
// - Codes 1000-1011 also merge ports two, three.
// - Strap 1111 leaves widths to negotiation.
// - Only x8, x4 and x1 widths attempted.
// - Start at native width, then fall back.
// - Wide links from lane zero; x1 anywhere.
// - Six general x4 ports plus south bridge port.
// - Only virtual channel zero offered.
// - No isochronous traffic support.
// - No end-to-end CRC generated or checked.
// - Strict ordering only, relaxed attribute ignored.
// - No-snoop inbound traffic skips cache snoop.
// - Forward PM messages, turn-off, collect acks.
// - No active state power management, no L0s.
// - Uncorrectable data goes out poisoned.
// - Largest payload is 256 bytes.
`timescale 1ns/1ps
`default_nettype none
module pcie_port_width_partitioning
  import pcie_port_width_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [STRAP_W-1:0] i_link_width_strap,
  input wire try_rsp_s [NUM_PORTS-1:0] i_try_rsp,
  output try_req_s [NUM_PORTS-1:0] o_try_req,
  output port_stat_s [NUM_PORTS-1:0] o_port_stat,
  output logic [NUM_PORTS-1:0][LANES-1:0] o_lane_en,
  output logic o_strap_taken,
  output logic [STRAP_W-1:0] o_strap_value,
  output logic o_strap_reserved,
  output logic o_autonomous,
  output caps_s o_caps,
  input wire inb_s i_inbound,
  output logic o_inb_valid,
  output logic o_snoop_req,
  output logic o_poison,
  output logic o_strict_order,
  input wire logic i_pme_turn_off,
  input wire logic [NUM_PORTS-1:0] i_pme_to_ack,
  output logic [NUM_PORTS-1:0] o_pme_turn_off_msg,
  output logic o_pme_all_acked,
  input wire logic i_pm_msg_valid,
  input wire logic [PM_MSG_W-1:0] i_pm_msg,
  output logic o_pm_fwd_valid,
  output logic [PM_MSG_W-1:0] o_pm_fwd_msg
);

  // Strap pins are asynchronous to the core clock.
  logic [STRAP_W-1:0] strap_meta_ff;
  logic [STRAP_W-1:0] strap_sync_ff;
  logic [SETTLE_W-1:0] settle_ff;
  logic strap_taken_ff;
  logic [STRAP_W-1:0] strap_ff;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      strap_meta_ff <= '0;
      strap_sync_ff <= '0;
    end else begin
      strap_meta_ff <= i_link_width_strap;
      strap_sync_ff <= strap_meta_ff;
    end
  end

  // The async reset cannot load a pin, so the strap is taken once the
  // synchroniser has refilled after release and never again.
  wire settle_done = (settle_ff == SETTLE_W'(STRAP_SETTLE));
  wire take_strap = settle_done && !strap_taken_ff;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      settle_ff <= '0;
    end else if (!settle_done) begin
      settle_ff <= SETTLE_W'(settle_ff + 1'b1);
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      strap_taken_ff <= 1'b0;
      strap_ff <= '0;
    end else if (take_strap) begin
      strap_taken_ff <= 1'b1;
      strap_ff <= strap_sync_ff;
    end
  end

  // Strap decode.
  wire strap_auto = (strap_ff == STRAP_AUTO);
  wire strap_lo_grp = ((strap_ff & ~STRAP_VALID_MASK) == STRAP_FIXED_LO);
  wire strap_hi_grp = ((strap_ff & ~STRAP_VALID_MASK) == STRAP_FIXED_HI);
  wire strap_fixed = strap_lo_grp || strap_hi_grp;
  wire strap_rsvd = !strap_fixed && !strap_auto;

  // Reserved codes fall back to all ports at x4, the safest partition.
  wire [NUM_PAIRS-1:0] strap_merge;
  assign strap_merge[0] = strap_fixed && strap_ff[STRAP_MERGE23_BIT];
  assign strap_merge[1] = strap_fixed && strap_ff[STRAP_MERGE45_BIT];
  assign strap_merge[2] = strap_fixed && strap_ff[STRAP_MERGE67_BIT];

  // Autonomous pairing, only used under the negotiation strap.
  logic [NUM_PAIRS-1:0] auto_merge_ff;
  logic [NUM_PAIRS-1:0] merge_now;
  logic [NUM_PAIRS-1:0] merge_prev_ff;
  logic [NUM_PORTS-1:0] id_valid_ff;
  logic [NUM_PORTS-1:0][ID_W-1:0] id_ff;
  logic [NUM_PORTS-1:0] up_w;
  logic [NUM_PORTS-1:0] failed_w;
  logic [NUM_PAIRS-1:0] pair_collapse;

  assign merge_now = strap_auto ? auto_merge_ff : strap_merge;

  // A change of pairing retrains both halves of that pair.
  wire [NUM_PAIRS-1:0] merge_change = merge_now ^ merge_prev_ff;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      merge_prev_ff <= '0;
    end else begin
      merge_prev_ff <= merge_now;
    end
  end

  // Far link identity seen on each port during its own training.
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_id
      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          id_valid_ff[p] <= 1'b0;
          id_ff[p] <= '0;
        end else if (i_try_rsp[p].id_valid) begin
          id_valid_ff[p] <= 1'b1;
          id_ff[p] <= i_try_rsp[p].id;
        end
      end
    end
  endgenerate

  genvar k;
  generate
    for (k = 0; k < NUM_PAIRS; k++) begin : g_pair
      localparam int LO = 2 * k + 1;
      localparam int HI = 2 * k + 2;
      // Both halves answering with one far identity means one device.
      assign pair_collapse[k] = strap_auto && !auto_merge_ff[k]
        && id_valid_ff[LO] && id_valid_ff[HI]
        && (id_ff[LO] == id_ff[HI]);

      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          auto_merge_ff[k] <= 1'b0;
        end else if (pair_collapse[k]) begin
          auto_merge_ff[k] <= 1'b1;
        end
      end
    end
  endgenerate

  // Port index 0 is the south bridge port, 1 to 6 are ports two to seven.
  width_e [NUM_PORTS-1:0] native_w;
  logic [NUM_PORTS-1:0] enable_w;
  logic [NUM_PORTS-1:0] restart_w;
  logic [NUM_PORTS-1:0] merged_away_w;
  logic [NUM_PORTS-1:0][OWNER_W-1:0] owner_w;
  try_req_s [NUM_PORTS-1:0] req_w;

  assign native_w[SB_PORT] = WIDTH_X4;
  assign merged_away_w[SB_PORT] = 1'b0;
  assign owner_w[SB_PORT] = OWNER_W'(SB_PORT);
  assign restart_w[SB_PORT] = 1'b0;

  generate
    for (k = 0; k < NUM_PAIRS; k++) begin : g_native
      localparam int LO = 2 * k + 1;
      localparam int HI = 2 * k + 2;
      // The lower port of a merged pair runs x8; the upper one goes quiet.
      assign native_w[LO] = merge_now[k] ? WIDTH_X8 : WIDTH_X4;
      assign native_w[HI] = merge_now[k] ? WIDTH_NONE : WIDTH_X4;
      assign merged_away_w[LO] = 1'b0;
      assign merged_away_w[HI] = merge_now[k];
      assign owner_w[LO] = OWNER_W'(LO);
      assign owner_w[HI] = merge_now[k] ? OWNER_W'(LO) : OWNER_W'(HI);
      assign restart_w[LO] = merge_change[k];
      assign restart_w[HI] = merge_change[k];
    end
  endgenerate

  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_train
      assign enable_w[p] = strap_taken_ff && (native_w[p] != WIDTH_NONE);

      port_width_trainer u_trainer (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_enable(enable_w[p]),
        .i_restart(restart_w[p]),
        .i_native(native_w[p]),
        .i_rsp(i_try_rsp[p]),
        .o_req(req_w[p]),
        .o_up(up_w[p]),
        .o_failed(failed_w[p])
      );
    end
  endgenerate

  assign o_try_req = req_w;

  // Lane usage follows the width being attempted or held.
  logic [NUM_PORTS-1:0][LANES-1:0] lane_sel;
  logic [NUM_PORTS-1:0][LANES-1:0] lane_en_ff;
  port_stat_s [NUM_PORTS-1:0] stat_ff;

  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_lane
      wire active = req_w[p].req || up_w[p];
      wire [LANES-1:0] one_lane = LANES'(1) << req_w[p].lane;
      if ((p % 2) == 0 && p != SB_PORT) begin : g_upper
        // Upper half of a pair lends its lanes to the lower port at x8.
        wire lo_x8 = merged_away_w[p] && (req_w[p-1].req || up_w[p-1])
          && (req_w[p-1].width == WIDTH_X8);
        assign lane_sel[p] = lo_x8 ? LANES_ALL
          : !active ? LANES_NONE
          : (req_w[p].width == WIDTH_X1) ? one_lane
          : LANES_ALL;
      end else begin : g_lower
        assign lane_sel[p] = !active ? LANES_NONE
          : (req_w[p].width == WIDTH_X1) ? one_lane
          : LANES_ALL;
      end

      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          lane_en_ff[p] <= LANES_NONE;
          stat_ff[p] <= '0;
        end else begin
          lane_en_ff[p] <= lane_sel[p];
          stat_ff[p] <= '{
            up: up_w[p],
            failed: failed_w[p],
            width: up_w[p] ? req_w[p].width : WIDTH_NONE,
            merged_away: merged_away_w[p],
            ctrl_owner: owner_w[p]
          };
        end
      end
    end
  endgenerate

  assign o_lane_en = lane_en_ff;
  assign o_port_stat = stat_ff;

  logic auto_ff;
  logic rsvd_ff;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      auto_ff <= 1'b0;
      rsvd_ff <= 1'b0;
    end else begin
      auto_ff <= strap_taken_ff && strap_auto;
      rsvd_ff <= strap_taken_ff && strap_rsvd;
    end
  end

  assign o_strap_taken = strap_taken_ff;
  assign o_strap_value = strap_ff;
  assign o_autonomous = auto_ff;
  assign o_strap_reserved = rsvd_ff;

  // Fixed capabilities advertised by every port.
  assign o_caps = CAPS_FIXED;

  // Inbound attribute handling.
  logic inb_valid_ff;
  logic snoop_ff;
  logic poison_ff;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      inb_valid_ff <= 1'b0;
      snoop_ff <= 1'b0;
      poison_ff <= 1'b0;
    end else begin
      inb_valid_ff <= i_inbound.valid;
      snoop_ff <= i_inbound.valid && !i_inbound.no_snoop;
      poison_ff <= i_inbound.valid && i_inbound.uncorrectable;
    end
  end

  assign o_inb_valid = inb_valid_ff;
  assign o_snoop_req = snoop_ff;
  assign o_poison = poison_ff;
  // The relaxed attribute is accepted but never acted on.
  assign o_strict_order = 1'b1;

  // Turn-off broadcast and acknowledge collection over the ports that are up.
  logic [NUM_PORTS-1:0] turn_off_ff;
  logic [NUM_PORTS-1:0] ack_pend_ff;
  logic all_acked_ff;
  logic collecting_ff;

  wire [NUM_PORTS-1:0] ack_pend_next = ack_pend_ff & ~i_pme_to_ack;
  wire start_turn_off = i_pme_turn_off && !collecting_ff;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      turn_off_ff <= '0;
      ack_pend_ff <= '0;
      collecting_ff <= 1'b0;
      all_acked_ff <= 1'b0;
    end else begin
      turn_off_ff <= start_turn_off ? up_w : '0;
      all_acked_ff <= 1'b0;
      if (start_turn_off) begin
        ack_pend_ff <= up_w;
        collecting_ff <= 1'b1;
      end else if (collecting_ff) begin
        ack_pend_ff <= ack_pend_next;
        if (ack_pend_next == '0) begin
          collecting_ff <= 1'b0;
          all_acked_ff <= 1'b1;
        end
      end
    end
  end

  assign o_pme_turn_off_msg = turn_off_ff;
  assign o_pme_all_acked = all_acked_ff;

  // Power messages pass straight through; the hub itself never sleeps.
  logic pm_valid_ff;
  logic [PM_MSG_W-1:0] pm_msg_ff;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pm_valid_ff <= 1'b0;
      pm_msg_ff <= '0;
    end else begin
      pm_valid_ff <= i_pm_msg_valid;
      if (i_pm_msg_valid) begin
        pm_msg_ff <= i_pm_msg;
      end
    end
  end

  assign o_pm_fwd_valid = pm_valid_ff;
  assign o_pm_fwd_msg = pm_msg_ff;

endmodule
`default_nettype wire

// file: design/pcie_port_width_pkg.sv
package pcie_port_width_pkg;

  localparam int NUM_PORTS = 7;
  localparam int NUM_PAIRS = 3;
  localparam int SB_PORT = 0;
  localparam int STRAP_W = 4;
  localparam int LANES = 4;
  localparam int LANE_IDX_W = 2;
  localparam int ID_W = 8;
  localparam int OWNER_W = 3;
  localparam int PM_MSG_W = 8;
  localparam int MAX_PAYLOAD_BYTES = 256;
  localparam int STRAP_SETTLE = 2;
  localparam int SETTLE_W = 2;

  localparam logic [LANE_IDX_W-1:0] LAST_LANE = 2'h3;
  localparam logic [LANES-1:0] LANES_ALL = 4'hf;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;

  localparam logic [STRAP_W-1:0] STRAP_AUTO = 4'hf;
  localparam int STRAP_MERGE23_BIT = 3;
  localparam int STRAP_MERGE45_BIT = 1;
  localparam int STRAP_MERGE67_BIT = 0;
  localparam logic [STRAP_W-1:0] STRAP_VALID_MASK = 4'h3;
  localparam logic [STRAP_W-1:0] STRAP_FIXED_LO = 4'h0;
  localparam logic [STRAP_W-1:0] STRAP_FIXED_HI = 4'h8;

  localparam logic [7:0] VC_MASK_VC0 = 8'h01;
  localparam logic [2:0] MAX_PAYLOAD_CODE = 3'h1;

  typedef enum logic [1:0] {
    WIDTH_NONE,
    WIDTH_X1,
    WIDTH_X4,
    WIDTH_X8
  } width_e;

  typedef struct packed {
    logic req;
    width_e width;
    logic [LANE_IDX_W-1:0] lane;
  } try_req_s;

  typedef struct packed {
    logic done;
    logic pass;
    logic id_valid;
    logic [ID_W-1:0] id;
  } try_rsp_s;

  typedef struct packed {
    logic up;
    logic failed;
    width_e width;
    logic merged_away;
    logic [OWNER_W-1:0] ctrl_owner;
  } port_stat_s;

  typedef struct packed {
    logic [7:0] vc_mask;
    logic isoch;
    logic ecrc_gen;
    logic ecrc_check;
    logic relaxed_order;
    logic aspm;
    logic l0s;
    logic can_power_down;
    logic pm_cap_present;
    logic [2:0] max_payload;
  } caps_s;

  typedef struct packed {
    logic valid;
    logic no_snoop;
    logic relaxed;
    logic uncorrectable;
  } inb_s;

  localparam caps_s CAPS_FIXED = '{
    vc_mask: VC_MASK_VC0,
    isoch: 1'b0,
    ecrc_gen: 1'b0,
    ecrc_check: 1'b0,
    relaxed_order: 1'b0,
    aspm: 1'b0,
    l0s: 1'b0,
    can_power_down: 1'b0,
    pm_cap_present: 1'b1,
    max_payload: MAX_PAYLOAD_CODE
  };

endpackage

// file: design/port_width_trainer.sv
`timescale 1ns/1ps
`default_nettype none
module port_width_trainer
  import pcie_port_width_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_restart,
  input wire width_e i_native,
  input wire try_rsp_s i_rsp,
  output try_req_s o_req,
  output logic o_up,
  output logic o_failed
);

  typedef enum logic [1:0] {
    T_IDLE,
    T_WAIT,
    T_UP,
    T_FAIL
  } train_e;

  train_e state_ff;
  train_e nxt_state;
  width_e width_ff;
  width_e nxt_width;
  logic [LANE_IDX_W-1:0] lane_ff;
  logic [LANE_IDX_W-1:0] nxt_lane;

  wire last_lane = (lane_ff == LAST_LANE);

  // Only x8, x4 and x1 are ever attempted; a failure at x8 or x4 steps one width down, a failure at x1 moves to the next lane, or to T_FAIL on the last lane.
  always_comb begin
    nxt_state = state_ff;
    nxt_width = width_ff;
    nxt_lane = lane_ff;
    case (state_ff)
      T_IDLE: begin
        if (i_enable) begin
          nxt_state = T_WAIT;
          nxt_width = i_native;
          nxt_lane = '0;
        end
      end
      T_WAIT: begin
        if (i_rsp.done && i_rsp.pass) begin
          nxt_state = T_UP;
        end else if (i_rsp.done) begin
          case (width_ff)
            WIDTH_X8: nxt_width = WIDTH_X4;
            WIDTH_X4: nxt_width = WIDTH_X1;
            WIDTH_X1: begin
              // A single lane may form on any of the four positions.
              if (last_lane) begin
                nxt_state = T_FAIL;
              end else begin
                nxt_lane = LANE_IDX_W'(lane_ff + 1'b1);
              end
            end
            default: nxt_state = T_FAIL;
          endcase
        end
      end
      T_UP: begin
        // A dropped link retrains from the native width again.
        if (i_rsp.done && !i_rsp.pass) begin
          nxt_state = T_WAIT;
          nxt_width = i_native;
          nxt_lane = '0;
        end
      end
      T_FAIL: nxt_state = T_FAIL;
      default: nxt_state = T_IDLE;
    endcase
    if (i_restart || !i_enable) begin
      nxt_state = T_IDLE;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= T_IDLE;
      width_ff <= WIDTH_NONE;
      lane_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      width_ff <= nxt_width;
      lane_ff <= nxt_lane;
    end
  end

  assign o_req = '{req: (state_ff == T_WAIT), width: width_ff, lane: lane_ff};
  assign o_up = (state_ff == T_UP);
  assign o_failed = (state_ff == T_FAIL);

endmodule
`default_nettype wire

// file: bench/far_end_model.sv
`timescale 1ns/1ps
`default_nettype none
module far_end_model
  import pcie_port_width_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire try_req_s [NUM_PORTS-1:0] i_req,
  input wire width_e i_cap [NUM_PORTS],
  input wire logic [LANE_IDX_W-1:0] i_x1_lane [NUM_PORTS],
  input wire logic [ID_W-1:0] i_far_id [NUM_PORTS],
  input wire logic [NUM_PORTS-1:0] i_drop,
  output var try_rsp_s [NUM_PORTS-1:0] o_rsp
);
  logic [ID_W-1:0] noise_ff;
  logic [NUM_PORTS-1:0] go;
  logic [NUM_PORTS-1:0] ok;
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      // One reply per attempt, so a reply never lands on the next attempt too.
      go[p] = i_req[p].req && !o_rsp[p].done;
      ok[p] = i_req[p].width <= i_cap[p] && i_req[p].lane == (i_req[p].width == WIDTH_X1 ? i_x1_lane[p] : 2'h0);
    end
  end
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_rsp <= '0;
      noise_ff <= 8'h00;
    end else begin
      noise_ff <= noise_ff + 8'h3b;
      for (int p = 0; p < NUM_PORTS; p++) begin
        // A drop request answers a link that is up with a failure, as a lost link would.
        o_rsp[p].done <= go[p] || i_drop[p];
        // Between replies the answer lines carry junk, as a real far end would.
        o_rsp[p].pass <= go[p] ? ok[p] : noise_ff[p] && !i_drop[p];
        o_rsp[p].id_valid <= go[p];
        o_rsp[p].id <= go[p] ? i_far_id[p] : noise_ff;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/pcie_port_width_partitioning_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pcie_port_width_partitioning_chk
  import pcie_port_width_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire try_rsp_s [NUM_PORTS-1:0] i_try_rsp,
  input wire try_req_s [NUM_PORTS-1:0] o_try_req,
  input wire port_stat_s [NUM_PORTS-1:0] o_port_stat,
  input wire logic o_strap_taken,
  input wire logic [STRAP_W-1:0] o_strap_value,
  input wire caps_s o_caps,
  input wire inb_s i_inbound,
  input wire logic o_snoop_req,
  input wire logic o_poison,
  input wire logic o_strict_order,
  input wire logic i_pm_msg_valid,
  input wire logic [PM_MSG_W-1:0] i_pm_msg,
  input wire logic o_pm_fwd_valid,
  input wire logic [PM_MSG_W-1:0] o_pm_fwd_msg
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  chk_strap_held: assert property (o_strap_taken && $past(o_strap_taken) |-> $stable(o_strap_value))
    else $error("strap value moved");
  chk_snoop_skip: assert property (i_inbound.valid |=> o_snoop_req == !$past(i_inbound.no_snoop))
    else $error("snoop request wrong");
  chk_poison_mark: assert property (i_inbound.valid |=> o_poison == $past(i_inbound.uncorrectable))
    else $error("poison mark wrong");
  chk_pm_forward: assert property (i_pm_msg_valid |=> o_pm_fwd_valid && o_pm_fwd_msg == $past(i_pm_msg))
    else $error("pm message not forwarded");
  chk_vc_only: assert property (o_caps.vc_mask == 8'h01)
    else $error("channel mask wrong");
  chk_strict_order: assert property (o_strict_order && !o_caps.relaxed_order)
    else $error("ordering not strict");
  chk_no_aspm: assert property (!o_caps.aspm && !o_caps.l0s)
    else $error("link power saving offered");
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    sequence s_fail(width_e w);
      o_try_req[p].req && o_try_req[p].width == w && i_try_rsp[p].done && !i_try_rsp[p].pass;
    endsequence
    chk_step_x4: assert property (s_fail(WIDTH_X8) |=> o_try_req[p].req && o_try_req[p].width == WIDTH_X4)
      else $error("x8 failure did not step to x4");
    chk_step_x1: assert property (s_fail(WIDTH_X4) |=> o_try_req[p].width == WIDTH_X1
      && o_try_req[p].lane == 2'h0)
      else $error("x4 failure did not step to x1");
    chk_wide_lane0: assert property (o_try_req[p].req && o_try_req[p].width != WIDTH_X1
      |-> o_try_req[p].lane == 2'h0)
      else $error("wide link off lane zero");
    chk_width_set: assert property (o_try_req[p].req |-> o_try_req[p].width != WIDTH_NONE)
      else $error("attempt without width");
    chk_merged_owner: assert property (o_port_stat[p].merged_away
      |-> o_port_stat[p].ctrl_owner == OWNER_W'(p - 1))
      else $error("merged port owner wrong");
  end
endmodule
`default_nettype wire

// file: bench/pcie_port_width_partitioning_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pcie_port_width_partitioning_bench;
  import pcie_port_width_pkg::*;
  logic i_clock;
  logic i_rst;
  logic [STRAP_W-1:0] i_link_width_strap;
  try_rsp_s [NUM_PORTS-1:0] i_try_rsp;
  try_req_s [NUM_PORTS-1:0] o_try_req;
  port_stat_s [NUM_PORTS-1:0] o_port_stat;
  logic [NUM_PORTS-1:0][LANES-1:0] o_lane_en;
  logic o_strap_taken, o_strap_reserved, o_autonomous, o_inb_valid, o_snoop_req, o_poison;
  logic o_strict_order, i_pme_turn_off, o_pme_all_acked, i_pm_msg_valid, o_pm_fwd_valid;
  logic [STRAP_W-1:0] o_strap_value;
  caps_s o_caps;
  inb_s i_inbound;
  logic [NUM_PORTS-1:0] i_pme_to_ack, o_pme_turn_off_msg, fin, drop;
  logic [PM_MSG_W-1:0] i_pm_msg, o_pm_fwd_msg;
  width_e cap [NUM_PORTS];
  logic [LANE_IDX_W-1:0] x1l [NUM_PORTS];
  logic [ID_W-1:0] fid [NUM_PORTS];
  int n_fail, samples_checked, cycles;

  pcie_port_width_partitioning dut_u (.*);
  far_end_model far_u (.i_clock(i_clock), .i_rst(i_rst), .i_req(o_try_req), .i_cap(cap),
    .i_x1_lane(x1l), .i_far_id(fid), .i_drop(drop), .o_rsp(i_try_rsp));

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      fin[p] = o_port_stat[p].up | o_port_stat[p].failed | o_port_stat[p].merged_away;
    end
  end

  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 10000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic defaults();
    for (int p = 0; p < NUM_PORTS; p++) begin
      cap[p] = WIDTH_X8;
      x1l[p] = 2'h0;
      fid[p] = 8'h10 + 8'(p);
    end
  endtask

  // Strap is set while reset is held, so it is stable well before capture.
  task automatic rst_run(input logic [3:0] s);
    i_rst = 1'b1;
    i_link_width_strap = s;
    repeat (5) @(negedge i_clock);
    i_rst = 1'b0;
    for (int i = 0; i < 300; i++) begin
      @(negedge i_clock);
      if (i > 40 && &fin)
        break;
    end
  endtask

  function automatic width_e wexp(int p, logic m);
    width_e n;
    n = m ? WIDTH_X8 : WIDTH_X4;
    return cap[p] < n ? cap[p] : n;
  endfunction

  function automatic logic [3:0] lanes(width_e w, logic [1:0] l);
    return w == WIDTH_X1 ? 4'h1 << l : (w == WIDTH_NONE ? 4'h0 : 4'hf);
  endfunction

  task automatic check_ports(input logic [2:0] mg);
    logic m;
    width_e w;
    for (int p = 0; p < NUM_PORTS; p++) begin
      m = p > 0 && mg[(p - 1) / 2];
      if (m && p % 2 == 0) begin
        w = wexp(p - 1, 1'b1);
        cmp(o_port_stat[p].merged_away, 1, "merged flag");
        cmp(o_port_stat[p].ctrl_owner, p - 1, "owner");
        cmp(o_lane_en[p], w == WIDTH_X8 ? 4'hf : 4'h0, "upper lanes");
      end else begin
        w = wexp(p, m);
        cmp(o_port_stat[p].merged_away, 0, "split flag");
        cmp(o_port_stat[p].up, w != WIDTH_NONE, "up");
        cmp(o_port_stat[p].failed, w == WIDTH_NONE, "failed");
        if (w != WIDTH_NONE)
          cmp(o_port_stat[p].width, w, "width");
        cmp(o_lane_en[p], lanes(w, x1l[p]), "lanes");
      end
    end
  endtask

  task automatic t_strap_table();
    logic [3:0] s;
    for (int k = 0; k < 8; k++) begin
      s = {k[2], 1'b0, k[1:0]};
      defaults();
      rst_run(s);
      cmp(o_strap_value, s, "strap value");
      cmp(o_strap_reserved, 0, "reserved");
      check_ports({s[0], s[1], s[3]});
    end
    $display("test strap_table done");
  endtask

  task automatic t_fallback();
    defaults();
    cap[0] = WIDTH_X1;
    x1l[0] = 2'h3;
    cap[1] = WIDTH_NONE;
    cap[3] = WIDTH_X4;
    cap[5] = WIDTH_X1;
    x1l[5] = 2'h2;
    rst_run(4'h3);
    check_ports(3'b110);
    $display("test fallback done");
  endtask

  task automatic t_reserved_hold();
    defaults();
    rst_run(4'h7);
    cmp(o_strap_reserved, 1, "reserved flag");
    cmp(o_strap_taken, 1, "strap taken");
    i_link_width_strap = 4'hb;
    repeat (20) @(negedge i_clock);
    cmp(o_strap_value, 4'h7, "strap held");
    check_ports(3'b000);
    $display("test reserved_hold done");
  endtask

  task automatic t_auto();
    defaults();
    fid[3] = 8'h55;
    fid[4] = 8'h55;
    rst_run(4'hf);
    cmp(o_autonomous, 1, "autonomous");
    check_ports(3'b010);
    $display("test auto done");
  endtask

  // Runs on the links left up by the autonomous case: all but port index 4.
  task automatic t_side();
    cmp(o_caps, {8'h01, 8'h01, 3'h1}, "caps");
    for (int k = 0; k < 4; k++) begin
      i_inbound = {1'b1, k[0], 1'b1, k[1]};
      @(negedge i_clock);
      cmp({o_inb_valid, o_snoop_req, o_poison}, {1'b1, !k[0], k[1]}, "inbound");
    end
    i_inbound = '0;
    i_pm_msg_valid = 1'b1;
    i_pm_msg = 8'ha5;
    @(negedge i_clock);
    i_pm_msg_valid = 1'b0;
    cmp({o_pm_fwd_valid, o_pm_fwd_msg}, {1'b1, 8'ha5}, "pm forward");
    i_pme_turn_off = 1'b1;
    @(negedge i_clock);
    i_pme_turn_off = 1'b0;
    i_pme_to_ack = 7'h3f;
    cmp(o_pme_turn_off_msg, 7'h6f, "turn off");
    @(negedge i_clock);
    i_pme_to_ack = 7'h00;
    cmp(o_pme_all_acked, 0, "early acked");
    @(negedge i_clock);
    i_pme_to_ack = 7'h40;
    @(negedge i_clock);
    i_pme_to_ack = 7'h00;
    cmp(o_pme_all_acked, 1, "all acked");
    $display("test side done");
  endtask

  // A drop on the south bridge port retrains it from x4 down to the one good lane.
  task automatic t_drop();
    cap[0] = WIDTH_X1;
    x1l[0] = 2'h1;
    drop = 7'h01;
    @(negedge i_clock);
    drop = 7'h00;
    repeat (30) @(negedge i_clock);
    cmp(o_port_stat[0].up, 1, "drop up");
    cmp(o_port_stat[0].width, WIDTH_X1, "drop width");
    cmp(o_lane_en[0], 4'h2, "drop lane");
    $display("test drop done");
  endtask

  initial begin
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    i_rst = 1'b1;
    i_link_width_strap = 4'h0;
    i_inbound = '0;
    i_pme_turn_off = 1'b0;
    i_pme_to_ack = '0;
    drop = '0;
    i_pm_msg_valid = 1'b0;
    i_pm_msg = 8'h00;
    defaults();
    t_strap_table();
    t_fallback();
    t_reserved_hold();
    t_auto();
    t_side();
    t_drop();
    summarize();
  end
endmodule

bind pcie_port_width_partitioning pcie_port_width_partitioning_chk chk_u (.*);
`default_nettype wire
